/* dv/pls_config_bank_assertions.sv */
// Checker of the bank's behaviour at its ports
`timescale 1ns/1ps
module pls_config_bank_assertions (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_col0_alt_function,
  input wire logic       i_col1_alt_function,
  input wire logic       i_row0_alt_function,
  input wire logic       o_pulse_out_a,
  input wire logic       o_cell_event,
  input wire logic       o_cell_irq_active,
  input wire logic       o_scan_start,
  input wire logic       o_precharge,
  input wire logic [5:0] o_row_is_key,
  input wire logic       o_row0_oe,
  input wire logic       o_col0_out,
  input wire logic       o_col0_oe,
  input wire logic       o_col1_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_row_select_follows: assert property (
    i_reg_wr && i_reg_addr == 8'h3A |-> ##2 o_row_is_key == $past(i_reg_wdata[5:0], 2))
    else $error("row select bits differ from write");
  a_unmapped_read_zero: assert property (
    i_reg_rd && (i_reg_addr < 8'h35 || i_reg_addr > 8'h3A) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_scan_reserved_zero: assert property (
    i_reg_rd && i_reg_addr == 8'h39 |=> (o_reg_rdata & 8'hF4) == 8'h00)
    else $error("scan timing reserved bits set");
  a_flop_reserved_zero: assert property (
    i_reg_rd && i_reg_addr == 8'h37 |=> o_reg_rdata[7:2] == 6'h00)
    else $error("flop control reserved bits set");
  a_col0_oe_follows: assert property (i_col0_alt_function [*3] |-> o_col0_oe)
    else $error("column 0 not driven");
  a_col1_oe_quiet: assert property (!i_col1_alt_function [*3] |-> !o_col1_oe)
    else $error("column 1 driven without alternate");
  a_col0_carries_gen: assert property (
    (o_col0_oe && $stable(o_pulse_out_a)) [*3] |-> o_col0_out == o_pulse_out_a)
    else $error("column 0 does not carry first generator");
  a_row0_oe_alt: assert property (
    (i_row0_alt_function && !o_row_is_key[0]) [*3] |-> o_row0_oe)
    else $error("row 0 not driving cell output");
  a_event_needs_level: assert property (o_cell_event |-> ##[0:1] o_cell_irq_active)
    else $error("event without active level");
  a_precharge_on_scan: assert property (o_scan_start |-> ##[0:1] o_precharge)
    else $error("scan start without precharge");
  a_no_scan_idle: assert property ((o_row_is_key == 6'h00) [*3] |-> !o_scan_start)
    else $error("scan with no rows selected");
  a_event_off_quiet: assert property (
    i_reg_wr && i_reg_addr == 8'h38 && !i_reg_wdata[1] |-> ##3 !o_cell_irq_active)
    else $error("interrupt level active while events disabled");
  c_event: cover property (o_cell_event);
  c_scan: cover property (o_scan_start);
  c_row_write: cover property (i_reg_wr && i_reg_addr == 8'h3A);
endmodule
bind pls_config_bank pls_config_bank_assertions CHK (.*);

/* dv/pls_config_bank_bench.sv */
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module pls_config_bank_bench;
  localparam int MS = 20;
  logic       clk, rst, wr, rd, ca, cb, cc, alt0, alt1, altr;
  logic [7:0] addr, wdata, rdata, r, d;
  logic [7:0] dla, pra, ona, dlb, prb, onb;
  logic       pa, pb, cy, cf, cev, cirq, scan, pre, r0o, r0e, c0o, c0e, c1o, c1e;
  logic [5:0] rows;
  logic [6:0] f;
  logic [7:0] mk [6] = '{8'hFF, 8'h7F, 8'h03, 8'h07, 8'h0B, 8'h3F};
  int         fails = 0, checks = 0, cyc = 0, evs = 0, ha, hb, ev0, gap, pw;
  pls_host HOST (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd),
    .i_rdata(rdata));
  pls_config_bank #(.P_MS_CYCLES(MS), .P_PRECHARGE_SHORT_CYCLES(3),
    .P_PRECHARGE_LONG_CYCLES(6)) DUT (.i_clk(clk), .i_rst(rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_gen_a_delay(dla), .i_gen_a_period(pra), .i_gen_a_on_time(ona), .i_gen_b_delay(dlb),
    .i_gen_b_period(prb), .i_gen_b_on_time(onb), .i_cell_input_a(ca), .i_cell_input_b(cb),
    .i_cell_input_c(cc), .i_col0_alt_function(alt0), .i_col1_alt_function(alt1),
    .i_row0_alt_function(altr), .o_pulse_out_a(pa), .o_pulse_out_b(pb), .o_cell_output(cy),
    .o_cell_filtered(cf), .o_cell_event(cev), .o_cell_irq_active(cirq), .o_scan_start(scan),
    .o_precharge(pre), .o_row_is_key(rows), .o_row0_out(r0o), .o_row0_oe(r0e),
    .o_col0_out(c0o), .o_col0_oe(c0e), .o_col1_out(c1o), .o_col1_oe(c1e));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    evs <= evs + int'(cev === 1'b1);
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic count_hi(input int n);
    ha = 0;
    hb = 0;
    repeat (n) begin
      wait_cy(1);
      ha += int'(pa === 1'b1);
      hb += int'(pb === 1'b1);
    end
  endtask
  // Interval between two scan starts and the precharge cycles inside it
  task automatic scan_gap();
    int k;
    k = 0;
    while (scan !== 1'b1 && k < 2000) begin
      wait_cy(1);
      k++;
    end
    gap = 0;
    pw = int'(pre === 1'b1);
    do begin
      wait_cy(1);
      gap++;
      if (scan !== 1'b1) pw += int'(pre === 1'b1);
    end while (scan !== 1'b1 && gap < 2000);
  endtask
  // Host never pairs slow on time with fast period
  function automatic logic [7:0] fix_gen(input logic [7:0] v);
    v[pls_pkg::BIT_GEN_A_PRD_TB] |= v[pls_pkg::BIT_GEN_A_ON_TB];
    v[pls_pkg::BIT_GEN_B_PRD_TB] |= v[pls_pkg::BIT_GEN_B_ON_TB];
    return v;
  endfunction
  function automatic logic exp_cell(input logic [6:0] g, input logic a, b, c);
    logic x, y, z, o;
    x = a ^ g[3];
    y = b ^ g[4];
    z = c ^ g[5];
    case (g[2:0])
      3'h1: o = x & y & z;
      3'h2: o = x | y | z;
      3'h3: o = x ^ y ^ z;
      3'h5: o = x;
      3'h6: o = y;
      3'h7: o = z;
      default: o = 1'b0;
    endcase
    return o ^ g[6];
  endfunction
  initial begin
    void'($urandom(99));
    {rst, ca, cb, cc, alt0, alt1, altr} = 7'h40;
    {dla, pra, ona, dlb, prb, onb} = '0;
    wait_cy(4);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      HOST.read(8'h35 + 8'(i), r);
      check(r, 8'h00);
      d = 8'($urandom);
      if (i == 0) d = fix_gen(d);
      HOST.write(8'h35 + 8'(i), d);
      HOST.read(8'h35 + 8'(i), r);
      check(r, d & mk[i]);
      HOST.write(8'h35 + 8'(i), 8'h00);
    end
    HOST.write(8'h3B, 8'hFF);
    HOST.read(8'h3B, r);
    check(r, 8'h00);
    {alt0, alt1, altr} = 3'h7;
    {pra, prb} = {8'h04, 8'h04};
    ona = 8'($urandom_range(1, 3));
    onb = 8'($urandom_range(1, 3));
    HOST.write(8'h35, 8'h19);
    wait_cy(10);
    count_hi(320);
    check(16'(ha), 16'(80 * ona));
    check(16'(hb), 16'(320 - 80 * onb));
    HOST.write(8'h35, 8'h08);
    wait_cy(5);
    count_hi(300);
    check(16'(ha), 16'd0);
    check(16'(hb), 16'd300);
    check({c1o, c1e}, 2'h3);
    {pra, ona} = {8'h01, 8'h19};
    HOST.write(8'h35, 8'h30);
    // First period is cut short by the free-running slow tick, so skip past it
    wait_cy(2600);
    count_hi(250 * MS);
    check(16'(ha), 16'(50 * MS));
    HOST.write(8'h35, 8'h00);
    {pra, ona} = {8'h02, 8'h01};
    HOST.write(8'h35, 8'h70);
    wait_cy(10);
    count_hi(250 * MS);
    check(16'(ha), 16'(125 * MS));
    HOST.write(8'h35, 8'h00);
    HOST.write(8'h38, 8'h04);
    for (int s = 0; s < 8; s++) begin
      repeat (3) begin
        f = 7'($urandom);
        f[2:0] = 3'(s);
        {ca, cb, cc} = 3'($urandom);
        if (s == 0) f[6] = 1'b0;
        if (s >= 1 && s <= 3) cc = f[5] ^ (s == 1);
        if (s == 4) begin
          cb = 1'b0;
          HOST.write(8'h36, {1'b0, f});
          HOST.write(8'h37, {6'h00, 1'($urandom), 1'b1});
          wait_cy(12);
          check(cy, f[6]);
          HOST.write(8'h37, 8'h02);
          wait_cy(12);
          check(cy, !f[6]);
          HOST.write(8'h37, 8'h00);
        end else begin
          HOST.write(8'h36, {1'b0, f});
          wait_cy(12);
          check({cy, r0o}, {2{exp_cell(f, ca, cb, cc)}});
        end
      end
    end
    ca = 1'b0;
    HOST.write(8'h36, 8'h05);
    HOST.write(8'h38, 8'h03);
    wait_cy(80);
    ev0 = evs;
    ca = 1'b1;
    wait_cy(20);
    check(cf, 1'b0);
    wait_cy(60);
    check(cf, 1'b1);
    check(cirq, 1'b1);
    check(16'(evs - ev0), 16'd1);
    HOST.write(8'h38, 8'h06);
    wait_cy(3);
    check(cirq, 1'b0);
    ca = 1'b0;
    wait_cy(12);
    check(cirq, 1'b1);
    HOST.write(8'h38, 8'h04);
    ev0 = evs;
    ca = 1'b1;
    wait_cy(12);
    check(16'(evs - ev0), 16'd0);
    check(cirq, 1'b0);
    HOST.write(8'h3A, 8'h01);
    for (int s = 0; s < 4; s++) begin
      d = {4'h0, 1'($urandom), 1'b0, 2'(s)};
      HOST.write(8'h39, d);
      scan_gap();
      scan_gap();
      check(16'(gap), 16'((s + 1) * 10 * MS));
      check(16'(pw), d[3] ? 16'd6 : 16'd3);
    end
    HOST.write(8'h3A, 8'h00);
    give_verdict();
  end
endmodule

/* dv/pls_host.sv */
// Host model that reaches the bank one byte per access
`timescale 1ns/1ps
module pls_host (
  input  wire logic       i_clk,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_rd,
  input  wire logic [7:0] i_rdata
);
  initial begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
    o_rd    = 1'b0;
  end
  // Lines are inverted on release so a stale value never looks live
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd   = 1'b1;
    @(posedge i_clk);
    #1;
    d      = i_rdata;
    o_rd   = 1'b0;
    o_addr = ~a;
  endtask
endmodule

/* hdl/pls_config_bank.sv */
// Configuration bank with pulse generators, logic cell, scan timing and row pin selection
//
// Overview of operation
// - Disabled generator holds off level; enabled runs
// - Invert clear: on time drives high
// - Second generator inverted: on time drives low
// - On timebase bit: 1 ms or 125 ms
// - Period timebase bit: 1 ms or 125 ms
// - Three-bit select picks logic cell function
// - Each cell input inverted by own bit
// - Output invert bit inverts cell output
// - Preset bit set forces cell flop set unless wipe bit set
// - Wipe bit set clears cell flop
// - Filtered cell output debounced unless bypass bit set
// - Events only when event enable bit set
// - Level bit picks active cell output level
// - Precharge 100 us or 200 us
// - Scan interval 10, 20, 30, 40 ms
// - Row select bits make pins keypad rows
// - Column 0 alternate drives first generator
// - Column 1 alternate drives second generator
// - Row 0 alternate drives cell output unless row select bit 0 makes it a keypad row
// - Period equals count times period unit
`timescale 1ns/1ps
module pls_config_bank #(
  parameter int P_MS_CYCLES              = pls_pkg::MS_CYCLES,
  parameter int P_PRECHARGE_SHORT_CYCLES = pls_pkg::PRECHARGE_SHORT_CYCLES,
  parameter int P_PRECHARGE_LONG_CYCLES  = pls_pkg::PRECHARGE_LONG_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  input  wire logic [7:0] i_gen_a_delay,
  input  wire logic [7:0] i_gen_a_period,
  input  wire logic [7:0] i_gen_a_on_time,
  input  wire logic [7:0] i_gen_b_delay,
  input  wire logic [7:0] i_gen_b_period,
  input  wire logic [7:0] i_gen_b_on_time,
  input  wire logic       i_cell_input_a,
  input  wire logic       i_cell_input_b,
  input  wire logic       i_cell_input_c,
  input  wire logic       i_col0_alt_function,
  input  wire logic       i_col1_alt_function,
  input  wire logic       i_row0_alt_function,
  output logic            o_pulse_out_a,
  output logic            o_pulse_out_b,
  output logic            o_cell_output,
  output logic            o_cell_filtered,
  output logic            o_cell_event,
  output logic            o_cell_irq_active,
  output logic            o_scan_start,
  output logic            o_precharge,
  output logic      [5:0] o_row_is_key,
  output logic            o_row0_out,
  output logic            o_row0_oe,
  output logic            o_col0_out,
  output logic            o_col0_oe,
  output logic            o_col1_out,
  output logic            o_col1_oe
);
  localparam int MS_W  = $clog2(P_MS_CYCLES + 1);
  localparam int PRE_W = $clog2(P_PRECHARGE_LONG_CYCLES + 1);
  localparam int DB_W  = $clog2(pls_pkg::DEBOUNCE_CYCLES + 1);

  logic [7:0]      pulse_generator_control;
  logic [7:0]      logic_cell_function;
  logic [7:0]      logic_flipflop_control;
  logic [7:0]      logic_event_control;
  logic [7:0]      scan_timing;
  logic [7:0]      row_pin_select;

  logic [MS_W-1:0] ms_cnt;
  logic [7:0]      slow_cnt;
  logic            tick_fast;
  logic            tick_slow;

  logic [2:0]      sync1;
  logic [2:0]      sync2;
  logic [2:0]      sync3;
  logic [2:0]      in_stable;
  logic [2:0]      in_eff;
  logic            prev_clk_in;
  logic            cell_flop;
  logic            next_cell_raw;
  logic            cell_core;
  logic [DB_W-1:0] db_cnt;
  logic            db_level;
  logic            cell_filt_src;
  logic            prev_filt;

  logic [5:0]      scan_ms;
  logic [5:0]      scan_limit;
  logic [PRE_W-1:0] pre_cnt;
  logic            pulse_a;
  logic            pulse_b;

  // Register writes; reserved bits are masked so they never store
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_generator_control <= pls_pkg::RESET_VALUE;
      logic_cell_function     <= pls_pkg::RESET_VALUE;
      logic_flipflop_control  <= pls_pkg::RESET_VALUE;
      logic_event_control     <= pls_pkg::RESET_VALUE;
      scan_timing             <= pls_pkg::RESET_VALUE;
      row_pin_select          <= pls_pkg::RESET_VALUE;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        pls_pkg::ADDR_PULSE_CTRL:  pulse_generator_control <= i_reg_wdata & pls_pkg::MASK_PULSE;
        pls_pkg::ADDR_CELL_FUNC:   logic_cell_function <= i_reg_wdata & pls_pkg::MASK_FUNC;
        pls_pkg::ADDR_FLOP_CTRL:   logic_flipflop_control <= i_reg_wdata & pls_pkg::MASK_FLOP;
        pls_pkg::ADDR_EVENT_CTRL:  logic_event_control <= i_reg_wdata & pls_pkg::MASK_EVENT;
        pls_pkg::ADDR_SCAN_TIMING: scan_timing <= i_reg_wdata & pls_pkg::MASK_SCAN;
        pls_pkg::ADDR_ROW_SELECT:  row_pin_select <= i_reg_wdata & pls_pkg::MASK_ROW;
        default: ;
      endcase
    end
  end

  // Read data registered; unmapped addresses return zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        pls_pkg::ADDR_PULSE_CTRL:  o_reg_rdata <= pulse_generator_control;
        pls_pkg::ADDR_CELL_FUNC:   o_reg_rdata <= logic_cell_function;
        pls_pkg::ADDR_FLOP_CTRL:   o_reg_rdata <= logic_flipflop_control;
        pls_pkg::ADDR_EVENT_CTRL:  o_reg_rdata <= logic_event_control;
        pls_pkg::ADDR_SCAN_TIMING: o_reg_rdata <= scan_timing;
        pls_pkg::ADDR_ROW_SELECT:  o_reg_rdata <= row_pin_select;
        default:                   o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // Shared timebase; the slow tick lands on a fast tick so both units stay aligned
  assign tick_fast = (ms_cnt == MS_W'(P_MS_CYCLES - 1));
  assign tick_slow = tick_fast && (slow_cnt == 8'(pls_pkg::SLOW_TICKS - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ms_cnt   <= '0;
      slow_cnt <= 8'h00;
    end else begin
      ms_cnt <= tick_fast ? '0 : ms_cnt + MS_W'(1);
      if (tick_slow) begin
        slow_cnt <= 8'h00;
      end else if (tick_fast) begin
        slow_cnt <= slow_cnt + 8'h01;
      end
    end
  end

  // Slow on time with fast period is unsupported and is left undefined here
  pls_pulse_gen u_gen_a (
    .i_clk             (i_clk),
    .i_rst             (i_rst),
    .i_run             (pulse_generator_control[pls_pkg::BIT_GEN_A_RUN]),
    .i_invert          (pulse_generator_control[pls_pkg::BIT_GEN_A_INVERT]),
    .i_on_timebase     (pulse_generator_control[pls_pkg::BIT_GEN_A_ON_TB]),
    .i_period_timebase (pulse_generator_control[pls_pkg::BIT_GEN_A_PRD_TB]),
    .i_delay           (i_gen_a_delay),
    .i_period          (i_gen_a_period),
    .i_on_time         (i_gen_a_on_time),
    .i_tick_fast       (tick_fast),
    .i_tick_slow       (tick_slow),
    .o_pulse           (pulse_a)
  );

  pls_pulse_gen u_gen_b (
    .i_clk             (i_clk),
    .i_rst             (i_rst),
    .i_run             (pulse_generator_control[pls_pkg::BIT_GEN_B_RUN]),
    .i_invert          (pulse_generator_control[pls_pkg::BIT_GEN_B_INVERT]),
    .i_on_timebase     (pulse_generator_control[pls_pkg::BIT_GEN_B_ON_TB]),
    .i_period_timebase (pulse_generator_control[pls_pkg::BIT_GEN_B_PRD_TB]),
    .i_delay           (i_gen_b_delay),
    .i_period          (i_gen_b_period),
    .i_on_time         (i_gen_b_on_time),
    .i_tick_fast       (tick_fast),
    .i_tick_slow       (tick_slow),
    .o_pulse           (pulse_b)
  );

  assign o_pulse_out_a = pulse_a;
  assign o_pulse_out_b = pulse_b;

  // Pin inputs pass three flops; a new value is taken once stages two and three agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1     <= 3'h0;
      sync2     <= 3'h0;
      sync3     <= 3'h0;
      in_stable <= 3'h0;
    end else begin
      sync1     <= {i_cell_input_c, i_cell_input_b, i_cell_input_a};
      sync2     <= sync1;
      sync3     <= sync2;
      in_stable <= (sync2 & ~(sync2 ^ sync3)) | (in_stable & (sync2 ^ sync3));
    end
  end

  assign in_eff = in_stable ^ {logic_cell_function[pls_pkg::BIT_IN_C_INVERT],
                               logic_cell_function[pls_pkg::BIT_IN_B_INVERT],
                               logic_cell_function[pls_pkg::BIT_IN_A_INVERT]};

  // Cell flop samples input A on a rising edge of input B; wipe overrides preset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cell_flop   <= 1'b0;
      prev_clk_in <= 1'b0;
    end else begin
      prev_clk_in <= in_eff[1];
      if (logic_flipflop_control[pls_pkg::BIT_FLOP_WIPE]) begin
        cell_flop <= 1'b0;
      end else if (logic_flipflop_control[pls_pkg::BIT_FLOP_PRESET]) begin
        cell_flop <= 1'b1;
      end else if (in_eff[1] && !prev_clk_in) begin
        cell_flop <= in_eff[0];
      end
    end
  end

  always_comb begin
    unique case (logic_cell_function[pls_pkg::FUNC_SEL_LSB +: 3])
      pls_pkg::FN_OFF:    next_cell_raw = 1'b0;
      pls_pkg::FN_AND:    next_cell_raw = &in_eff;
      pls_pkg::FN_OR:     next_cell_raw = |in_eff;
      pls_pkg::FN_XOR:    next_cell_raw = ^in_eff;
      pls_pkg::FN_FLOP:   next_cell_raw = cell_flop;
      pls_pkg::FN_PASS_A: next_cell_raw = in_eff[0];
      pls_pkg::FN_PASS_B: next_cell_raw = in_eff[1];
      pls_pkg::FN_PASS_C: next_cell_raw = in_eff[2];
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cell_core <= 1'b0;
    end else begin
      cell_core <= next_cell_raw ^ logic_cell_function[pls_pkg::BIT_OUT_INVERT];
    end
  end

  // Debounce: a level must hold a full window before it is accepted
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      db_cnt   <= '0;
      db_level <= 1'b0;
    end else if (cell_core == db_level) begin
      db_cnt <= '0;
    end else if (db_cnt == DB_W'(pls_pkg::DEBOUNCE_CYCLES - 1)) begin
      db_cnt   <= '0;
      db_level <= cell_core;
    end else begin
      db_cnt <= db_cnt + DB_W'(1);
    end
  end

  // Bypass lets glitches through to the event logic
  assign cell_filt_src = logic_event_control[pls_pkg::BIT_DEBOUNCE_BYPASS] ?
                         cell_core : db_level;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_filt         <= 1'b0;
      o_cell_filtered   <= 1'b0;
      o_cell_event      <= 1'b0;
      o_cell_irq_active <= 1'b0;
    end else begin
      prev_filt       <= cell_filt_src;
      o_cell_filtered <= cell_filt_src;
      // Event on entry into the active level only
      o_cell_event <= logic_event_control[pls_pkg::BIT_EVENT_EN] &&
                      (cell_filt_src != prev_filt) &&
                      (cell_filt_src == logic_event_control[pls_pkg::BIT_IRQ_LEVEL]);
      o_cell_irq_active <= logic_event_control[pls_pkg::BIT_EVENT_EN] &&
                           (cell_filt_src == logic_event_control[pls_pkg::BIT_IRQ_LEVEL]);
    end
  end

  // Scan scheduler runs only while some pin is a keypad row
  assign scan_limit = 6'(pls_pkg::SCAN_STEP_MS) *
                      (6'(scan_timing[pls_pkg::SCAN_INTERVAL_LSB +: 2]) + 6'h01);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scan_ms      <= 6'h00;
      o_scan_start <= 1'b0;
    end else begin
      o_scan_start <= 1'b0;
      if (row_pin_select[5:0] == 6'h00) begin
        scan_ms <= 6'h00;
      end else if (tick_fast) begin
        if (scan_ms + 6'h01 >= scan_limit) begin
          scan_ms      <= 6'h00;
          o_scan_start <= 1'b1;
        end else begin
          scan_ms <= scan_ms + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt     <= '0;
      o_precharge <= 1'b0;
    end else if (o_scan_start) begin
      pre_cnt     <= scan_timing[pls_pkg::BIT_PRECHARGE_LONG] ?
                     PRE_W'(P_PRECHARGE_LONG_CYCLES - 1) :
                     PRE_W'(P_PRECHARGE_SHORT_CYCLES - 1);
      o_precharge <= 1'b1;
    end else if (pre_cnt != '0) begin
      pre_cnt <= pre_cnt - PRE_W'(1);
    end else begin
      o_precharge <= 1'b0;
    end
  end

  // Pin function routing, registered so every pin output comes from a flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_row_is_key  <= 6'h00;
      o_cell_output <= 1'b0;
      o_row0_out    <= 1'b0;
      o_row0_oe     <= 1'b0;
      o_col0_out    <= 1'b0;
      o_col0_oe     <= 1'b0;
      o_col1_out    <= 1'b0;
      o_col1_oe     <= 1'b0;
    end else begin
      o_row_is_key  <= row_pin_select[5:0];
      o_cell_output <= cell_core;
      // A row select overrides the alternate function on row 0
      o_row0_out    <= cell_core;
      o_row0_oe     <= i_row0_alt_function && !row_pin_select[0];
      o_col0_out    <= pulse_a;
      o_col0_oe     <= i_col0_alt_function;
      o_col1_out    <= pulse_b;
      o_col1_oe     <= i_col1_alt_function;
    end
  end
endmodule

/* hdl/pls_pkg.sv */
// Package with register map, field positions, reset values and timing constants of the bank
package pls_pkg;
  localparam logic [7:0] ADDR_PULSE_CTRL  = 8'h35;
  localparam logic [7:0] ADDR_CELL_FUNC   = 8'h36;
  localparam logic [7:0] ADDR_FLOP_CTRL   = 8'h37;
  localparam logic [7:0] ADDR_EVENT_CTRL  = 8'h38;
  localparam logic [7:0] ADDR_SCAN_TIMING = 8'h39;
  localparam logic [7:0] ADDR_ROW_SELECT  = 8'h3A;

  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] MASK_PULSE  = 8'hFF;
  localparam logic [7:0] MASK_FUNC   = 8'h7F;
  localparam logic [7:0] MASK_FLOP   = 8'h03;
  localparam logic [7:0] MASK_EVENT  = 8'h07;
  localparam logic [7:0] MASK_SCAN   = 8'h0B;
  localparam logic [7:0] MASK_ROW    = 8'h3F;

  localparam int BIT_GEN_A_INVERT   = 7;
  localparam int BIT_GEN_A_ON_TB    = 6;
  localparam int BIT_GEN_A_PRD_TB   = 5;
  localparam int BIT_GEN_A_RUN      = 4;
  localparam int BIT_GEN_B_INVERT   = 3;
  localparam int BIT_GEN_B_ON_TB    = 2;
  localparam int BIT_GEN_B_PRD_TB   = 1;
  localparam int BIT_GEN_B_RUN      = 0;
  localparam int FUNC_SEL_LSB       = 0;
  localparam int BIT_IN_A_INVERT    = 3;
  localparam int BIT_IN_B_INVERT    = 4;
  localparam int BIT_IN_C_INVERT    = 5;
  localparam int BIT_OUT_INVERT     = 6;
  localparam int BIT_FLOP_WIPE      = 0;
  localparam int BIT_FLOP_PRESET    = 1;
  localparam int BIT_IRQ_LEVEL      = 0;
  localparam int BIT_EVENT_EN       = 1;
  localparam int BIT_DEBOUNCE_BYPASS = 2;
  localparam int SCAN_INTERVAL_LSB  = 0;
  localparam int BIT_PRECHARGE_LONG = 3;

  localparam logic [2:0] FN_OFF    = 3'h0;
  localparam logic [2:0] FN_AND    = 3'h1;
  localparam logic [2:0] FN_OR     = 3'h2;
  localparam logic [2:0] FN_XOR    = 3'h3;
  localparam logic [2:0] FN_FLOP   = 3'h4;
  localparam logic [2:0] FN_PASS_A = 3'h5;
  localparam logic [2:0] FN_PASS_B = 3'h6;
  localparam logic [2:0] FN_PASS_C = 3'h7;

  localparam int CLK_PERIOD_NS      = 10;
  localparam int TB_FAST_MS         = 1;
  localparam int TB_SLOW_MS         = 125;
  localparam int MS_CYCLES          = TB_FAST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SLOW_TICKS         = TB_SLOW_MS / TB_FAST_MS;
  localparam int PRECHARGE_SHORT_US = 100;
  localparam int PRECHARGE_LONG_US  = 200;
  localparam int PRECHARGE_SHORT_CYCLES = PRECHARGE_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int PRECHARGE_LONG_CYCLES  = PRECHARGE_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int SCAN_STEP_MS       = 10;
  localparam int DEBOUNCE_NS        = 500;
  localparam int DEBOUNCE_CYCLES    = DEBOUNCE_NS / CLK_PERIOD_NS;
endpackage

/* hdl/pls_pulse_gen.sv */
// One pulse generator: initial delay, period and on time counted in timebase ticks
`timescale 1ns/1ps
module pls_pulse_gen (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic       i_invert,
  input  wire logic       i_on_timebase,
  input  wire logic       i_period_timebase,
  input  wire logic [7:0] i_delay,
  input  wire logic [7:0] i_period,
  input  wire logic [7:0] i_on_time,
  input  wire logic       i_tick_fast,
  input  wire logic       i_tick_slow,
  output logic            o_pulse
);
  logic       prd_tick;
  logic       on_tick;
  logic       in_delay;
  logic [7:0] prd_cnt;
  logic [7:0] on_cnt;
  logic       active;

  assign prd_tick = i_period_timebase ? i_tick_slow : i_tick_fast;
  assign on_tick  = i_on_timebase ? i_tick_slow : i_tick_fast;
  // A zero period or zero on time never turns the output on
  assign active   = !in_delay && (i_period != 8'h00) && (on_cnt < i_on_time);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      in_delay <= 1'b1;
      prd_cnt  <= 8'h00;
      on_cnt   <= 8'h00;
    end else if (!i_run) begin
      in_delay <= 1'b1;
      prd_cnt  <= 8'h00;
      on_cnt   <= 8'h00;
    end else if (in_delay) begin
      if (prd_cnt >= i_delay) begin
        in_delay <= 1'b0;
        prd_cnt  <= 8'h00;
      end else if (prd_tick) begin
        prd_cnt <= prd_cnt + 8'h01;
      end
    end else begin
      // Period is count times the period unit, restarting both counters
      if (prd_tick && (prd_cnt + 8'h01 >= i_period)) begin
        prd_cnt <= 8'h00;
        on_cnt  <= 8'h00;
      end else begin
        if (prd_tick) begin
          prd_cnt <= prd_cnt + 8'h01;
        end
        if (on_tick && (on_cnt < i_on_time)) begin
          on_cnt <= on_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= (i_run && active) ^ i_invert;
    end
  end
endmodule
